// *** core/tis_port.sv ***
// Behaviour
// R01 - device only answers; host opens every transfer
// R02 - link runs at up to 400 kbit/s
// R03 - answer 0xBA/0xBB or 0x28/0x29 pair
// R04 - host picks pair via reset and interrupt
// R05 - interrupt output flags touch activity
// R06 - held in reset; strap caught at release
// R07 - write: 16-bit register address, data, each acked
// R08 - register pointer advances after every data byte; the code leaves it unchanged after a read byte that the host nacks
// R09 - read: repeated start, host nacks last, stops
// R10 - unmatched address: no ack, idle till start
`timescale 1ns/1ns
`default_nettype none

module tis_port
    import tis_pkg::*;
#(
    parameter int MEM_AW = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_host_rst_n,
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    input wire logic i_int_in,
    output logic o_int_out,
    output logic o_int_oe_n,
    input wire logic i_touch_event,
    output logic o_wr_strobe,
    output logic [REG_ADDR_W-1:0] o_wr_addr,
    output logic [7:0] o_wr_data
);

    // ==================================================================
    // crossings
    logic rst_pin_c;
    logic int_c;
    logic req_c;
    logic scl_s;
    logic sda_s;
    logic run_l;
    logic alt_l;
    logic ack_l;
    tis_core_t cr_q;
    tis_core_t cr_d;
    tis_link_t lk_q;
    tis_link_t lk_d;

    tis_sync #(.STAGES(3), .RST_VAL(1'b0)) u_rst_pin (.i_clk(i_core_clk), .i_rst(i_rst),
        .i_d(i_host_rst_n), .o_q(rst_pin_c));
    tis_sync #(.STAGES(3), .RST_VAL(1'b0)) u_int_pin (.i_clk(i_core_clk), .i_rst(i_rst),
        .i_d(i_int_in), .o_q(int_c));
    tis_sync #(.STAGES(2), .RST_VAL(1'b0)) u_req (.i_clk(i_core_clk), .i_rst(i_rst),
        .i_d(lk_q.req_tgl), .o_q(req_c));
    // oversampling at the link clock leaves dozens of samples per bit at 400 kbit/s
    tis_sync #(.STAGES(3), .RST_VAL(1'b1)) u_scl (.i_clk(i_link_clk), .i_rst(i_rst), // R02
        .i_d(i_scl), .o_q(scl_s));
    tis_sync #(.STAGES(3), .RST_VAL(1'b1)) u_sda (.i_clk(i_link_clk), .i_rst(i_rst),
        .i_d(i_sda_in), .o_q(sda_s));
    tis_sync #(.STAGES(2), .RST_VAL(1'b0)) u_run (.i_clk(i_link_clk), .i_rst(i_rst),
        .i_d(cr_q.run), .o_q(run_l));
    tis_sync #(.STAGES(2), .RST_VAL(1'b0)) u_alt (.i_clk(i_link_clk), .i_rst(i_rst),
        .i_d(cr_q.addr_alt), .o_q(alt_l));
    tis_sync #(.STAGES(2), .RST_VAL(1'b0)) u_ack (.i_clk(i_link_clk), .i_rst(i_rst),
        .i_d(cr_q.seen_tgl), .o_q(ack_l));

    // ==================================================================
    // core domain: reset pin, strap, interrupt line, write notices
    always_comb begin
        cr_d = cr_q;
        cr_d.wr_strobe = 1'b0;
        if (!rst_pin_c) begin
            // line released so the host can strap it
            cr_d.run = 1'b0; // R06
            cr_d.int_oe_n = 1'b1;
            cr_d.int_out = 1'b1;
            cr_d.int_cnt = '0;
        end else if (!cr_q.run) begin
            cr_d.run = 1'b1;
            cr_d.addr_alt = int_c; // R04 R06
            cr_d.int_oe_n = 1'b0;
        end else if (i_touch_event) begin
            // a new event restarts the pulse even mid-count
            cr_d.int_out = 1'b0; // R05
            cr_d.int_cnt = INT_CNT_W'(INT_PULSE_CYC - 1);
        end else if (cr_q.int_cnt != '0) begin
            cr_d.int_cnt = cr_q.int_cnt - 1'b1;
        end else begin
            cr_d.int_out = 1'b1;
        end
        if (req_c != cr_q.seen_tgl) begin
            // hold registers stay still until the toggle is echoed
            cr_d.seen_tgl = req_c;
            cr_d.wr_strobe = 1'b1;
            cr_d.wr_addr = lk_q.hold_addr;
            cr_d.wr_data = lk_q.hold_data;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cr_q <= CR_RST;
        end else begin
            cr_q <= cr_d;
        end
    end

    // ==================================================================
    // link domain: serial slave
    logic [7:0] mem [0:(1<<MEM_AW)-1];
    logic mem_we;
    logic [7:0] rd_byte;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [7:0] act_wr;
    logic [7:0] act_rd;

    assign scl_rise = scl_s && !lk_q.scl_p;
    assign scl_fall = !scl_s && lk_q.scl_p;
    assign start_c = scl_s && lk_q.scl_p && lk_q.sda_p && !sda_s;
    assign stop_c = scl_s && lk_q.scl_p && !lk_q.sda_p && sda_s;
    assign act_wr = alt_l ? ADDR_B_WR : ADDR_A_WR; // R03
    assign act_rd = alt_l ? ADDR_B_RD : ADDR_A_RD;
    assign rd_byte = mem[lk_q.ptr[MEM_AW-1:0]];

    always_comb begin
        lk_d = lk_q;
        mem_we = 1'b0;
        lk_d.scl_p = scl_s;
        lk_d.sda_p = sda_s;
        if (start_c) begin
            // repeated start lands here too
            lk_d.st = LS_RX; // R01 R09
            lk_d.kind = BK_DEV;
            lk_d.cnt = 4'h0;
            lk_d.sda_oe_n = 1'b1;
        end else if (stop_c) begin
            lk_d.st = LS_IDLE;
            lk_d.sda_oe_n = 1'b1;
        end else begin
            case (lk_q.st)
                LS_RX: begin
                    if (scl_rise) begin
                        lk_d.sh = {lk_q.sh[6:0], sda_s};
                        lk_d.cnt = lk_q.cnt + 4'h1;
                    end else if (scl_fall && lk_q.cnt == BYTE_DONE) begin
                        lk_d.st = LS_RX_ACK;
                        lk_d.sda_oe_n = 1'b0; // R07
                        lk_d.to_tx = 1'b0;
                        case (lk_q.kind)
                            BK_DEV: begin
                                if (lk_q.sh == act_wr) begin
                                    lk_d.kind = BK_RAH; // R03
                                end else if (lk_q.sh == act_rd) begin
                                    lk_d.to_tx = 1'b1; // R09
                                end else begin
                                    lk_d.st = LS_IDLE; // R10
                                    lk_d.sda_oe_n = 1'b1;
                                end
                            end
                            BK_RAH: begin
                                lk_d.ptr[15:8] = lk_q.sh; // R07
                                lk_d.kind = BK_RAL;
                            end
                            BK_RAL: begin
                                lk_d.ptr[7:0] = lk_q.sh;
                                lk_d.kind = BK_DATA;
                            end
                            default: begin
                                mem_we = 1'b1;
                                lk_d.ptr = lk_q.ptr + 16'h0001; // R08
                                // a notice still in flight drops this one
                                if (lk_q.req_tgl == ack_l) begin
                                    lk_d.req_tgl = !lk_q.req_tgl;
                                    lk_d.hold_addr = lk_q.ptr;
                                    lk_d.hold_data = lk_q.sh;
                                end
                            end
                        endcase
                    end
                end
                LS_RX_ACK: begin
                    if (scl_fall) begin
                        lk_d.cnt = 4'h0;
                        if (lk_q.to_tx) begin
                            lk_d.st = LS_TX;
                            lk_d.sh = rd_byte;
                            lk_d.sda_oe_n = rd_byte[7];
                        end else begin
                            lk_d.st = LS_RX;
                            lk_d.sda_oe_n = 1'b1;
                        end
                    end
                end
                LS_TX: begin
                    if (scl_fall) begin
                        if (lk_q.cnt == BYTE_LAST_BIT) begin
                            lk_d.st = LS_TX_ACK;
                            lk_d.sda_oe_n = 1'b1;
                        end else begin
                            lk_d.sh = {lk_q.sh[6:0], 1'b0};
                            lk_d.sda_oe_n = lk_q.sh[6];
                            lk_d.cnt = lk_q.cnt + 4'h1;
                        end
                    end
                end
                LS_TX_ACK: begin
                    if (scl_rise) begin
                        lk_d.more = !sda_s; // R09
                        if (!sda_s) begin
                            lk_d.ptr = lk_q.ptr + 16'h0001; // R08
                        end
                    end else if (scl_fall) begin
                        lk_d.cnt = 4'h0;
                        if (lk_q.more) begin
                            lk_d.st = LS_TX;
                            lk_d.sh = rd_byte;
                            lk_d.sda_oe_n = rd_byte[7];
                        end else begin
                            lk_d.st = LS_IDLE; // R09
                        end
                    end
                end
                default: begin
                    lk_d.sda_oe_n = 1'b1; // R01
                end
            endcase
        end
        if (!run_l) begin
            lk_d = LK_RST; // R06
            lk_d.req_tgl = lk_q.req_tgl;
            lk_d.hold_addr = lk_q.hold_addr;
            lk_d.hold_data = lk_q.hold_data;
            // track the lines while held, or a busy bus at release reads as a start
            lk_d.scl_p = scl_s;
            lk_d.sda_p = sda_s;
        end
    end

    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            lk_q <= LK_RST;
        end else begin
            lk_q <= lk_d;
        end
    end

    // register image has no reset; it holds what the host wrote
    always_ff @(posedge i_link_clk) begin
        if (mem_we) begin
            mem[lk_q.ptr[MEM_AW-1:0]] <= lk_q.sh;
        end
    end

    assign o_sda_out = lk_q.sda_out;
    assign o_sda_oe_n = lk_q.sda_oe_n;
    assign o_int_out = cr_q.int_out;
    assign o_int_oe_n = cr_q.int_oe_n;
    assign o_wr_strobe = cr_q.wr_strobe;
    assign o_wr_addr = cr_q.wr_addr;
    assign o_wr_data = cr_q.wr_data;

    // ==================================================================
    // checks
    sequence s_byte_done(tis_kind_t k);
        lk_q.st == LS_RX && lk_q.kind == k && lk_q.cnt == BYTE_DONE && scl_fall
            && !start_c && !stop_c && run_l;
    endsequence

    sequence s_nack_fall;
        lk_q.st == LS_TX_ACK && !lk_q.more && scl_fall && !start_c && !stop_c && run_l;
    endsequence

    AST_ADDR_ACK: assert property (@(posedge i_link_clk) disable iff (i_rst) // R03
        s_byte_done(BK_DEV) ##0 (lk_q.sh == act_wr || lk_q.sh == act_rd)
            |=> !o_sda_oe_n && lk_q.st == LS_RX_ACK)
        else $error("matching address not acknowledged");
    AST_ADDR_NACK: assert property (@(posedge i_link_clk) disable iff (i_rst) // R10
        s_byte_done(BK_DEV) ##0 (lk_q.sh != act_wr && lk_q.sh != act_rd)
            |=> o_sda_oe_n && lk_q.st == LS_IDLE)
        else $error("foreign address acknowledged");
    AST_IDLE_QUIET: assert property (@(posedge i_link_clk) disable iff (i_rst) // R01
        lk_q.st == LS_IDLE |-> o_sda_oe_n)
        else $error("data line driven while idle");
    AST_BYTE_ACK: assert property (@(posedge i_link_clk) disable iff (i_rst) // R07
        s_byte_done(BK_RAH) or s_byte_done(BK_RAL) |=> !o_sda_oe_n ##1 !o_sda_oe_n)
        else $error("register address byte not acknowledged");
    AST_PTR_WR: assert property (@(posedge i_link_clk) disable iff (i_rst) // R08
        s_byte_done(BK_DATA) |=> !o_sda_oe_n && lk_q.ptr == $past(lk_q.ptr) + 16'h0001)
        else $error("pointer not advanced after written byte");
    AST_PTR_RD: assert property (@(posedge i_link_clk) disable iff (i_rst) // R08
        lk_q.st == LS_TX_ACK && scl_rise && !sda_s && !start_c && !stop_c && run_l
            |=> lk_q.ptr == $past(lk_q.ptr) + 16'h0001 && lk_q.more)
        else $error("pointer not advanced after read byte");
    AST_NACK_END: assert property (@(posedge i_link_clk) disable iff (i_rst) // R09
        s_nack_fall |=> lk_q.st == LS_IDLE ##1 o_sda_oe_n)
        else $error("read goes on after host nack");
    AST_INT_PULSE: assert property (@(posedge i_core_clk) disable iff (i_rst) // R05
        i_touch_event && cr_q.run && rst_pin_c |=> (!o_int_out && !o_int_oe_n) [*8])
        else $error("interrupt pulse missing or short");
    AST_RST_HOLD: assert property (@(posedge i_core_clk) disable iff (i_rst) // R06
        !rst_pin_c |=> o_int_oe_n && !cr_q.run)
        else $error("device active while held in reset");
    AST_STRAP: assert property (@(posedge i_core_clk) disable iff (i_rst) // R06
        $rose(cr_q.run) |-> cr_q.addr_alt == $past(int_c) && !o_int_oe_n)
        else $error("address pair not taken from strap level");

endmodule : tis_port

`default_nettype wire

// *** core/tis_pkg.sv ***
package tis_pkg;

    // ==================================================================
    // slave addresses (write / read byte of each pair)
    localparam logic [7:0] ADDR_A_WR = 8'hBA;
    localparam logic [7:0] ADDR_A_RD = 8'hBB;
    localparam logic [7:0] ADDR_B_WR = 8'h28;
    localparam logic [7:0] ADDR_B_RD = 8'h29;

    // ==================================================================
    // link figures
    localparam int BIT_RATE_MAX_BPS = 400000;
    localparam int REG_ADDR_W = 16;
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
    localparam logic [3:0] BYTE_DONE = 4'h8;

    // ==================================================================
    // timing
    localparam int CORE_CLK_NS = 100;
    localparam int INT_PULSE_NS = 10000;
    // least time: round up to whole core cycles
    localparam int INT_PULSE_CYC = (INT_PULSE_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
    localparam int INT_CNT_W = $clog2(INT_PULSE_CYC + 1);

    // ==================================================================
    // link state
    typedef enum logic [2:0] {LS_IDLE, LS_RX, LS_RX_ACK, LS_TX, LS_TX_ACK} tis_lstate_t;
    typedef enum logic [1:0] {BK_DEV, BK_RAH, BK_RAL, BK_DATA} tis_kind_t;

    typedef struct packed {
        tis_lstate_t st;
        tis_kind_t kind;
        logic to_tx;
        logic more;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [REG_ADDR_W-1:0] ptr;
        logic sda_oe_n;
        logic sda_out;
        logic scl_p;
        logic sda_p;
        logic req_tgl;
        logic [REG_ADDR_W-1:0] hold_addr;
        logic [7:0] hold_data;
    } tis_link_t;

    localparam tis_link_t LK_RST = '{st: LS_IDLE, kind: BK_DEV, to_tx: 1'b0, more: 1'b0,
        cnt: 4'h0, sh: 8'h00, ptr: 16'h0000, sda_oe_n: 1'b1, sda_out: 1'b0,
        scl_p: 1'b1, sda_p: 1'b1, req_tgl: 1'b0, hold_addr: 16'h0000, hold_data: 8'h00};

    // ==================================================================
    // core state
    typedef struct packed {
        logic run;
        logic addr_alt;
        logic int_out;
        logic int_oe_n;
        logic [INT_CNT_W-1:0] int_cnt;
        logic seen_tgl;
        logic wr_strobe;
        logic [REG_ADDR_W-1:0] wr_addr;
        logic [7:0] wr_data;
    } tis_core_t;

    localparam tis_core_t CR_RST = '{run: 1'b0, addr_alt: 1'b0, int_out: 1'b1,
        int_oe_n: 1'b1, int_cnt: '0, seen_tgl: 1'b0, wr_strobe: 1'b0,
        wr_addr: 16'h0000, wr_data: 8'h00};

endpackage : tis_pkg

// *** core/tis_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

// first stage feeds only the second; with three or more stages the
// output moves only once the last two stages agree
module tis_sync #(
    parameter int STAGES = 3,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_d,
    output logic o_q
);

    typedef struct packed {
        logic [STAGES-1:0] chain;
        logic q;
    } tis_sync_state_t;

    tis_sync_state_t s_q;
    tis_sync_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.chain = {s_q.chain[STAGES-2:0], i_d};
        // a two-stage chain compares its last stage with itself, so stage 0 stays private
        if (s_q.chain[STAGES-1] == s_q.chain[(STAGES < 3) ? STAGES-1 : STAGES-2]) begin
            s_d.q = s_q.chain[STAGES-1];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= {{STAGES{RST_VAL}}, RST_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_q = s_q.q;

endmodule : tis_sync

`default_nettype wire

// *** test/tis_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// ==================================================================
// host master model: opens and closes every transfer, open drain
module tis_host_model #(
    parameter int HALF_NS = 1250
) (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    localparam int Q_NS = HALF_NS / 2;

    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // data moves a quarter period after scl falls, so hold and setup both get 625 ns
    task automatic put_bit(input logic b);
        o_sda_low = !b;
        #Q_NS;
        o_scl = 1'b1;
        #HALF_NS;
        o_scl = 1'b0;
        #Q_NS;
    endtask : put_bit

    task automatic get_bit(output logic b);
        o_sda_low = 1'b0;
        #Q_NS;
        o_scl = 1'b1;
        #Q_NS;
        b = i_sda;
        #Q_NS;
        o_scl = 1'b0;
        #Q_NS;
    endtask : get_bit

    // one shape serves both start and repeated start
    task automatic start();
        o_sda_low = 1'b0;
        #Q_NS;
        o_scl = 1'b1;
        #HALF_NS;
        o_sda_low = 1'b1;
        #HALF_NS;
        o_scl = 1'b0;
        #Q_NS;
    endtask : start

    task automatic stop();
        o_sda_low = 1'b1;
        #Q_NS;
        o_scl = 1'b1;
        #HALF_NS;
        o_sda_low = 1'b0;
        #HALF_NS;
    endtask : stop

    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i]);
        end
        get_bit(a);
        ack = !a;
    endtask : wbyte

    // last byte of a read gets a nack
    task automatic rbyte(input logic last, output logic [7:0] v);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            get_bit(b);
            v[i] = b;
        end
        put_bit(last);
    endtask : rbyte
endmodule : tis_host_model

`default_nettype wire

// *** test/tb_touch_i2c_slave_port.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb_touch_i2c_slave_port;
    import tis_pkg::*;

    // ==================================================================
    // clocks, wires, instances
    logic i_core_clk, i_link_clk, i_rst, i_host_rst_n, i_touch_event;
    logic host_int_en, host_int_lvl, scl, host_low, sda_w, int_w;
    logic o_sda_out, o_sda_oe_n, o_int_out, o_int_oe_n, o_wr_strobe;
    logic [REG_ADDR_W-1:0] o_wr_addr;
    logic [7:0] o_wr_data;
    logic [REG_ADDR_W-1:0] wa_log[$];
    logic [7:0] wd_log[$];
    int errors, checks;

    assign sda_w = (((o_sda_oe_n === 1'b0) && (o_sda_out === 1'b0)) || host_low) ? 1'b0 : 1'b1;
    // host strap wins while held, so the caught level never sees a glitch
    assign int_w = host_int_en ? host_int_lvl : ((o_int_oe_n === 1'b0) ? o_int_out : 1'b1);

    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    initial begin
        i_link_clk = 1'b0;
        #7;
        forever #32 i_link_clk = ~i_link_clk;
    end

    tis_port u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
        .i_host_rst_n(i_host_rst_n), .i_scl(scl), .i_sda_in(sda_w), .o_sda_out(o_sda_out),
        .o_sda_oe_n(o_sda_oe_n), .i_int_in(int_w), .o_int_out(o_int_out),
        .o_int_oe_n(o_int_oe_n), .i_touch_event(i_touch_event), .o_wr_strobe(o_wr_strobe),
        .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data));
    tis_host_model u_host (.i_sda(sda_w), .o_scl(scl), .o_sda_low(host_low));

    // strobe is launched on the rising edge, so look at it half a cycle later
    always @(negedge i_core_clk) begin
        if (o_wr_strobe === 1'b1) begin
            wa_log.push_back(o_wr_addr);
            wd_log.push_back(o_wr_data);
        end
    end

    // ==================================================================
    // helpers
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic probe(input logic [7:0] a, input logic exp);
        logic ack;
        u_host.start();
        u_host.wbyte(a, ack);
        u_host.stop();
        chk(ack === exp, "address answer wrong");
    endtask : probe

    task automatic strap(input logic lvl);
        @(negedge i_core_clk);
        i_host_rst_n = 1'b0;
        host_int_en = 1'b1;
        host_int_lvl = lvl;
        repeat (10) @(negedge i_core_clk);
        i_host_rst_n = 1'b1;
        // let go half a cycle before the port catches the strap and starts driving the line; the synchronizer still holds the strap level
        repeat (4) @(negedge i_core_clk);
        host_int_en = 1'b0;
        repeat (20) @(negedge i_core_clk);
        chk(o_int_oe_n === 1'b0 && o_int_out === 1'b1, "int not driven idle");
    endtask : strap

    // ==================================================================
    // scenarios
    task automatic t_reset_vals();
        chk(o_sda_oe_n === 1'b1 && o_int_oe_n === 1'b1 && o_int_out === 1'b1, "pins");
        chk(o_wr_strobe === 1'b0 && o_wr_addr === 16'h0000 && o_wr_data === 8'h00, "wr");
        $display("test reset_vals done");
    endtask : t_reset_vals

    task automatic t_dev_reset();
        @(negedge i_core_clk);
        i_touch_event = 1'b1;
        @(negedge i_core_clk);
        i_touch_event = 1'b0;
        chk(o_int_oe_n === 1'b1, "int driven in reset");
        probe(ADDR_A_WR, 1'b0);
        $display("test dev_reset done");
    endtask : t_dev_reset

    task automatic t_strap_a();
        logic a1, a2;
        strap(1'b0);
        probe(ADDR_A_WR, 1'b1);
        // a refused address must keep the port deaf until a fresh start
        u_host.start();
        u_host.wbyte(ADDR_B_WR, a1);
        u_host.wbyte(ADDR_A_WR, a2);
        u_host.stop();
        chk(a1 === 1'b0 && a2 === 1'b0, "refused address acked");
        $display("test strap_a done");
    endtask : t_strap_a

    task automatic t_write_read();
        logic [7:0] wdat[3] = '{8'h5A, 8'hC3, 8'h96};
        logic [7:0] v;
        logic ack;
        wa_log.delete();
        wd_log.delete();
        u_host.start();
        u_host.wbyte(ADDR_A_WR, ack);
        u_host.wbyte(8'h00, ack);
        chk(ack === 1'b1, "high address byte not acked");
        u_host.wbyte(8'hFE, ack);
        chk(ack === 1'b1, "low address byte not acked");
        for (int i = 0; i < 3; i++) begin
            u_host.wbyte(wdat[i], ack);
            chk(ack === 1'b1, "data byte not acked");
        end
        u_host.stop();
        repeat (20) @(negedge i_core_clk);
        chk(wa_log.size() == 3, "write notice count");
        for (int i = 0; i < wa_log.size() && i < 3; i++) begin
            chk(wa_log[i] === 16'h00FE + 16'(i) && wd_log[i] === wdat[i], "write notice");
        end
        u_host.start();
        u_host.wbyte(ADDR_A_WR, ack);
        u_host.wbyte(8'h00, ack);
        u_host.wbyte(8'hFE, ack);
        u_host.start();
        u_host.wbyte(ADDR_A_RD, ack);
        chk(ack === 1'b1, "read address not acked");
        for (int i = 0; i < 3; i++) begin
            u_host.rbyte(i == 2, v);
            chk(v === wdat[i], "read data");
        end
        u_host.stop();
        $display("test write_read done");
    endtask : t_write_read

    task automatic t_int();
        int n;
        @(negedge i_core_clk);
        i_touch_event = 1'b1;
        @(negedge i_core_clk);
        i_touch_event = 1'b0;
        n = 0;
        while (o_int_out === 1'b0 && n < 300) begin
            n++;
            @(negedge i_core_clk);
        end
        chk(n == INT_PULSE_CYC, "int pulse length");
        chk(o_int_out === 1'b1 && o_int_oe_n === 1'b0, "int idle");
        $display("test int done");
    endtask : t_int

    task automatic t_strap_b();
        strap(1'b1);
        probe(ADDR_B_WR, 1'b1);
        probe(ADDR_A_WR, 1'b0);
        $display("test strap_b done");
    endtask : t_strap_b

    // ==================================================================
    // main sequence and watchdog
    initial begin
        errors = 0;
        checks = 0;
        i_rst = 1'b1;
        i_host_rst_n = 1'b0;
        i_touch_event = 1'b0;
        host_int_en = 1'b0;
        host_int_lvl = 1'b1;
        repeat (20) @(negedge i_core_clk);
        t_reset_vals();
        i_rst = 1'b0;
        repeat (5) @(negedge i_core_clk);
        t_dev_reset();
        t_strap_a();
        t_write_read();
        t_int();
        t_strap_b();
        stop_test();
    end

    // 19 bytes of 22.5 us each; over four times that bounds a hang
    initial begin
        #2000000;
        errors++;
        stop_test();
    end
endmodule : tb_touch_i2c_slave_port

`default_nettype wire
